/* i2c_port_map.svh */
// Function
// RULE_01 - Answer seven-bit address 0x09 for both write and read direction bits.
// RULE_02 - Drive acknowledge on ninth clock after matching write address.
// RULE_03 - First byte after write address loads the pointer at its acknowledge.
// RULE_04 - Byte after a pointer byte goes to pending buffer, not applied.
// RULE_05 - Bytes alternate pointer then data without limit inside one write.
// RULE_06 - Write may end after any byte count by repeated START or STOP.
// RULE_07 - Pending data survives repeated STARTs, including other devices, unapplied.
// RULE_08 - STOP copies all pending values into command registers together.
// RULE_09 - Seven readable registers: three status, four writable command registers.
// RULE_10 - Read returns register chosen by latest pointer; one register per read.
// RULE_11 - After read address acknowledge, shift selected byte over eight clocks.
// RULE_12 - Clocks beyond the returned byte see data line released high.
// RULE_13 - In reads acknowledge only the address; release after one byte.
// RULE_14 - Master rewrites pointer to change register; rereads need only address.
// RULE_15 - Command read returns pending value if modified since last STOP.
// RULE_16 - Power loss resets both input current limit fields to 0x00 or 0x1F.
// RULE_17 - Without pending interrupt, status sampled at read address acknowledge.
// RULE_18 - Unmasked event drives interrupt low and freezes all three status registers.
// RULE_19 - Clearing interrupt releases frozen status, back to live sampling.
// RULE_20 - Master writes only pointers 0x00 to 0x02 and 0x06 to 0x07.
// RULE_21 - Combined read: write address, pointer, repeated START, read address, one byte.
// RULE_22 - Any byte written to 0x06 clears the pending interrupt at its acknowledge.
// RULE_23 - Never stretch or pull the serial clock line low.
// RULE_24 - Frames are eight bits MSB first, ninth clock carries receiver acknowledge.
// RULE_25 - Synchronise and glitch-filter clock and data before edge and condition detection.
`ifndef I2C_PORT_MAP_SVH
`define I2C_PORT_MAP_SVH
`define SLAVE_ADDR 7'h09
`define RW_WRITE 1'b0
`define RW_READ 1'b1
`define PTR_CMD0 8'h00
`define PTR_CMD1 8'h01
`define PTR_CMD2 8'h02
`define PTR_STAT0 8'h03
`define PTR_STAT1 8'h04
`define PTR_STAT2 8'h05
`define PTR_IMR 8'h06
`define PTR_SHIP 8'h07
`define IDX_IMR 2'h3
`define IDX_USB_LIMIT 2'h0
`define IDX_ADAPTER_LIMIT 2'h1
`define LIMIT_LSB 0
`define LIMIT_MSB 4
`define LIMIT_DEFAULT_LOW 5'h00
`define LIMIT_DEFAULT_HIGH 5'h1F
`define MASK_LSB 2
`define MASK_MSB 7
`define CMD_RESET 8'h00
`define STATUS_RESET 8'h00
`define PTR_RESET 8'h00
`define READ_IDLE 8'hFF
`define BITS_PER_BYTE 4'h8
`define CLK_MHZ 100
`define GLITCH_NS 30
`define GLITCH_CYC ((`GLITCH_NS * `CLK_MHZ + 999) / 1000)
`endif

/* i2c_port_pkg.sv */
package i2c_port_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_wr_byte, st_wr_ack, st_rd_byte, st_ignore
  } bus_state_t;

  typedef struct packed {
    bus_state_t st;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic ptr_phase;
    logic [7:0] ptr;
    logic [3:0][7:0] cmd;
    logic [3:0][7:0] pend;
    logic [3:0] mod;
    logic sda_oe;
    logic sda_out;
    logic irq_clear;
    logic status_sample;
  } port_state_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_c;
    logic [1:0] sda_c;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_state_t;

  typedef struct packed {
    logic [2:0][7:0] snap;
    logic irq;
    logic irq_b;
  } snap_state_t;
endpackage : i2c_port_pkg

/* line_events_if.sv */
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  modport src (output scl_rise, output scl_fall, output sda, output start, output stop);
  modport snk (input scl_rise, input scl_fall, input sda, input start, input stop);
endinterface : line_events_if

/* i2c_line_filter.sv */
`include "i2c_port_map.svh"
module i2c_line_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Filtered events
  line_events_if.src ev
);
  i2c_port_pkg::line_state_t s, next_s;

  // Follows the synced level only once it held for the filter time
  function automatic logic [2:0] filt_step(input logic raw, input logic filt,
                                           input logic [1:0] cnt);
    if (raw == filt) begin
      filt_step = {filt, 2'h0};
    end else if (cnt == 2'(`GLITCH_CYC - 1)) begin
      filt_step = {raw, 2'h0};
    end else begin
      filt_step = {filt, cnt + 2'h1};
    end
  endfunction : filt_step

  always_comb begin
    next_s = s;
    next_s.scl_s = {s.scl_s[0], scl_in}; // RULE_25
    next_s.sda_s = {s.sda_s[0], sda_in}; // RULE_25
    {next_s.scl_f, next_s.scl_c} = filt_step(s.scl_s[1], s.scl_f, s.scl_c); // RULE_25
    {next_s.sda_f, next_s.sda_c} = filt_step(s.sda_s[1], s.sda_f, s.sda_c); // RULE_25
    next_s.scl_rise = next_s.scl_f && !s.scl_f;
    next_s.scl_fall = !next_s.scl_f && s.scl_f;
    // Data edge while clock stays high marks START or STOP
    next_s.start = s.scl_f && next_s.scl_f && s.sda_f && !next_s.sda_f;
    next_s.stop = s.scl_f && next_s.scl_f && !s.sda_f && next_s.sda_f;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1, sda_f: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign ev.scl_rise = s.scl_rise;
  assign ev.scl_fall = s.scl_fall;
  assign ev.sda = s.sda_f;
  assign ev.start = s.start;
  assign ev.stop = s.stop;

  start_needs_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.start |-> $past(s.scl_f) && s.scl_f && !s.sda_f) // RULE_25
    else $error("start flagged without clock high");
endmodule : i2c_line_filter

/* status_snapshot.sv */
`include "i2c_port_map.svh"
module status_snapshot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Live status and events
  input wire logic [2:0][7:0] live,
  input wire logic [5:0] events,
  input wire logic [5:0] mask,
  // Control from the port
  input wire logic sample,
  input wire logic clear,
  // Results
  output logic [2:0][7:0] snap,
  output logic irq_b
);
  i2c_port_pkg::snap_state_t s, next_s;
  logic trig;

  always_comb begin
    next_s = s;
    trig = |(events & mask);
    // New event beats a same-cycle clear
    next_s.irq = (s.irq && !clear) || trig; // RULE_18 RULE_19
    next_s.irq_b = !next_s.irq; // RULE_18
    // Frozen while pending; otherwise caught at event or read acknowledge
    if (!s.irq && (trig || sample)) begin
      next_s.snap = live; // RULE_17 RULE_18
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{snap: {3{`STATUS_RESET}}, irq: 1'b0, irq_b: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign snap = s.snap;
  assign irq_b = s.irq_b;

  freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s.irq && !clear) |=> $stable(s.snap) && !s.irq_b) // RULE_18
    else $error("status changed while interrupt pending");
endmodule : status_snapshot

/* i2c_subaddressed_register_port.sv */
`include "i2c_port_map.svh"
module i2c_subaddressed_register_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial bus; clock is input only, never driven
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Charger side
  input wire logic [2:0][7:0] live_status,
  input wire logic [5:0] status_events,
  input wire logic input_power_lost,
  input wire logic resistor_programmed_limit_mode,
  output logic [3:0][7:0] command_regs,
  output logic irq_b
);
  // Whole port state, registered as one word
  i2c_port_pkg::port_state_t s, next_s;
  logic [2:0][7:0] snap;
  logic snap_irq_b;
  logic [2:0] wslot;
  logic [7:0] rd_val;
  logic [4:0] lim_val;

  // Filtered line events from the synchroniser
  line_events_if lev ();

  // Clock is only ever sampled, so the port cannot stretch it
  i2c_line_filter i_filter (
    .clk(clk),
    .rst_b(rst_b),
    .scl_in(scl_in), // RULE_23
    .sda_in(sda_in), // RULE_25
    .ev(lev)
  );

  // Status freeze and interrupt line live in their own block
  status_snapshot i_snapshot (
    .clk(clk),
    .rst_b(rst_b),
    .live(live_status),
    .events(status_events),
    .mask(s.cmd[`IDX_IMR][`MASK_MSB:`MASK_LSB]),
    .sample(s.status_sample),
    .clear(s.irq_clear),
    .snap(snap),
    .irq_b(snap_irq_b)
  );

  // Maps a pointer to a command slot; top bit flags a stored command location
  function automatic logic [2:0] cmd_slot(input logic [7:0] ptr);
    if (ptr == `PTR_CMD0) begin
      cmd_slot = {1'b1, 2'h0};
    end else if (ptr == `PTR_CMD1) begin
      cmd_slot = {1'b1, 2'h1};
    end else if (ptr == `PTR_CMD2) begin
      cmd_slot = {1'b1, 2'h2};
    end else if (ptr == `PTR_IMR) begin
      cmd_slot = {1'b1, `IDX_IMR};
    end else begin
      // Ship location takes writes but keeps nothing here
      cmd_slot = {1'b0, 2'h0};
    end
  endfunction : cmd_slot

  // Maps a pointer to a status slot; top bit flags a status location
  function automatic logic [2:0] stat_slot(input logic [7:0] ptr);
    if (ptr == `PTR_STAT0) begin
      stat_slot = {1'b1, 2'h0};
    end else if (ptr == `PTR_STAT1) begin
      stat_slot = {1'b1, 2'h1};
    end else if (ptr == `PTR_STAT2) begin
      stat_slot = {1'b1, 2'h2};
    end else begin
      stat_slot = {1'b0, 2'h0};
    end
  endfunction : stat_slot

  // Byte returned by a read: pending beats active until the next STOP
  function automatic logic [7:0] read_value(input logic [7:0] ptr,
                                            input logic [3:0][7:0] cmd,
                                            input logic [3:0][7:0] pend,
                                            input logic [3:0] mod,
                                            input logic [2:0][7:0] stat);
    logic [2:0] cs;
    logic [2:0] ss;
    cs = cmd_slot(ptr);
    ss = stat_slot(ptr);
    if (cs[2] && mod[cs[1:0]]) begin
      read_value = pend[cs[1:0]]; // RULE_15
    end else if (cs[2]) begin
      read_value = cmd[cs[1:0]]; // RULE_09
    end else if (ss[2]) begin
      read_value = stat[ss[1:0]]; // RULE_09
    end else begin
      // Unused and ship locations read as an idle line
      read_value = `READ_IDLE;
    end
  endfunction : read_value

  // Applies every modified slot in the same cycle
  function automatic logic [3:0][7:0] commit_all(input logic [3:0][7:0] cmd,
                                                 input logic [3:0][7:0] pend,
                                                 input logic [3:0] mod);
    commit_all = cmd;
    for (int i = 0; i < 4; i++) begin
      if (mod[i]) begin
        commit_all[i] = pend[i]; // RULE_08
      end
    end
  endfunction : commit_all

  // Limit field default chosen by the programming resistor
  function automatic logic [4:0] limit_default(input logic mode);
    if (mode) begin
      limit_default = `LIMIT_DEFAULT_HIGH;
    end else begin
      limit_default = `LIMIT_DEFAULT_LOW;
    end
  endfunction : limit_default

  always_comb begin
    wslot = cmd_slot(s.ptr);
    rd_val = read_value(s.ptr, s.cmd, s.pend, s.mod, snap);
    lim_val = limit_default(resistor_programmed_limit_mode);
    next_s = s;
    // Strobes to the snapshot last one cycle
    next_s.irq_clear = 1'b0;
    next_s.status_sample = 1'b0;
    if (lev.stop) begin
      // Group update: every pending byte takes effect together
      next_s.cmd = commit_all(s.cmd, s.pend, s.mod); // RULE_08
      next_s.mod = 4'h0;
      next_s.sda_oe = 1'b0;
      next_s.sda_out = 1'b1;
      next_s.st = i2c_port_pkg::st_idle; // RULE_06
    end else if (lev.start) begin
      // Repeated START leaves pending data unapplied
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
      next_s.sda_out = 1'b1;
      next_s.st = i2c_port_pkg::st_addr; // RULE_06 RULE_07
    end else begin
      case (s.st)
        i2c_port_pkg::st_addr: begin
          if (lev.scl_rise) begin
            next_s.shift = {s.shift[6:0], lev.sda}; // RULE_24
            next_s.cnt = s.cnt + 4'h1;
          end else if (lev.scl_fall && s.cnt == `BITS_PER_BYTE) begin
            if (s.shift[7:1] == `SLAVE_ADDR) begin
              // Both direction bits are answered
              next_s.rw = s.shift[0]; // RULE_01
              next_s.sda_oe = 1'b1; // RULE_02
              next_s.sda_out = 1'b0;
              next_s.status_sample = (s.shift[0] == `RW_READ); // RULE_17
              next_s.st = i2c_port_pkg::st_addr_ack;
            end else begin
              // Another device owns this transfer
              next_s.st = i2c_port_pkg::st_ignore;
            end
          end
        end
        i2c_port_pkg::st_addr_ack: begin
          if (lev.scl_fall) begin
            next_s.cnt = 4'h0;
            if (s.rw == `RW_READ) begin
              // Snapshot was taken at the acknowledge, so it is settled here
              next_s.shift = rd_val; // RULE_10 RULE_21
              next_s.sda_out = rd_val[7]; // RULE_11
              next_s.st = i2c_port_pkg::st_rd_byte;
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.sda_out = 1'b1;
              next_s.ptr_phase = 1'b1; // RULE_05
              next_s.st = i2c_port_pkg::st_wr_byte;
            end
          end
        end
        i2c_port_pkg::st_wr_byte: begin
          if (lev.scl_rise) begin
            next_s.shift = {s.shift[6:0], lev.sda}; // RULE_24
            next_s.cnt = s.cnt + 4'h1;
          end else if (lev.scl_fall && s.cnt == `BITS_PER_BYTE) begin
            next_s.sda_oe = 1'b1;
            next_s.sda_out = 1'b0;
            next_s.st = i2c_port_pkg::st_wr_ack;
            if (s.ptr_phase) begin
              next_s.ptr = s.shift; // RULE_03
            end else if (wslot[2]) begin
              next_s.pend[wslot[1:0]] = s.shift; // RULE_04
              next_s.mod[wslot[1:0]] = 1'b1; // RULE_15
            end
            // Any byte to the mask location clears the request
            if (!s.ptr_phase && s.ptr == `PTR_IMR) begin
              next_s.irq_clear = 1'b1; // RULE_22
            end
          end
        end
        i2c_port_pkg::st_wr_ack: begin
          if (lev.scl_fall) begin
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b0;
            next_s.sda_out = 1'b1;
            next_s.ptr_phase = !s.ptr_phase; // RULE_05
            next_s.st = i2c_port_pkg::st_wr_byte;
          end
        end
        i2c_port_pkg::st_rd_byte: begin
          if (lev.scl_fall) begin
            if (s.cnt == 4'h7) begin
              // One byte only; later clocks see the pulled-up line
              next_s.sda_oe = 1'b0; // RULE_12 RULE_13 RULE_21
              next_s.sda_out = 1'b1;
              next_s.st = i2c_port_pkg::st_ignore;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.sda_out = s.shift[6]; // RULE_11
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        default: begin
          // Idle and ignore wait for the next START or STOP
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
    // Power loss rewrites the limit fields with no bus transfer
    if (input_power_lost) begin
      next_s.cmd[`IDX_USB_LIMIT][`LIMIT_MSB:`LIMIT_LSB] = lim_val; // RULE_16
      next_s.cmd[`IDX_ADAPTER_LIMIT][`LIMIT_MSB:`LIMIT_LSB] = lim_val; // RULE_16
    end
  end

  // Synchronous reset; only constants are loaded
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{st: i2c_port_pkg::st_idle, ptr: `PTR_RESET, cmd: {4{`CMD_RESET}},
             sda_out: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from registers
  assign sda_out = s.sda_out;
  assign sda_oe = s.sda_oe;
  assign command_regs = s.cmd;
  assign irq_b = snap_irq_b;

  // Properties key on registered line events, so filter lag never matters
  // End of a pointer byte, with no START or STOP in the same cycle
  sequence ptr_byte_end;
    s.st == i2c_port_pkg::st_wr_byte && s.ptr_phase && lev.scl_fall &&
      s.cnt == `BITS_PER_BYTE && !lev.start && !lev.stop;
  endsequence

  // End of a data byte, with no START or STOP in the same cycle
  sequence data_byte_end;
    s.st == i2c_port_pkg::st_wr_byte && !s.ptr_phase && lev.scl_fall &&
      s.cnt == `BITS_PER_BYTE && !lev.start && !lev.stop;
  endsequence

  // Clock fall that moves the read byte on by one bit
  sequence read_bit_edge;
    s.st == i2c_port_pkg::st_rd_byte && lev.scl_fall && s.cnt != 4'h7 &&
      !lev.start && !lev.stop;
  endsequence

  // Last clock fall of an address byte
  sequence addr_byte_end;
    s.st == i2c_port_pkg::st_addr && lev.scl_fall && s.cnt == `BITS_PER_BYTE &&
      !lev.start && !lev.stop;
  endsequence

  // Clock fall that ends an acknowledge the port drove
  sequence ack_clock_end;
    (s.st == i2c_port_pkg::st_addr_ack || s.st == i2c_port_pkg::st_wr_ack) &&
      lev.scl_fall && !lev.start && !lev.stop;
  endsequence

  addr_ack_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
    s.st == i2c_port_pkg::st_addr_ack |-> s.sda_oe && !s.sda_out)
    else $error("address acknowledge not driven low");

  pointer_load_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
    ptr_byte_end |=> s.ptr == $past(s.shift) && s.st == i2c_port_pkg::st_wr_ack)
    else $error("pointer not loaded at its acknowledge");

  pending_store_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
    data_byte_end ##0 (s.ptr == `PTR_CMD2) |=> s.pend[2] == $past(s.shift) && s.mod[2])
    else $error("data byte not held as pending");

  mask_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_22
    data_byte_end ##0 (s.ptr == `PTR_IMR) |=> s.irq_clear)
    else $error("mask write did not clear the request");

  pending_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
    lev.start && !input_power_lost |=> s.cmd == $past(s.cmd))
    else $error("command changed at a repeated start");

  stop_commit_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
    lev.stop |=> s.mod == 4'h0 && s.st == i2c_port_pkg::st_idle && !s.sda_oe)
    else $error("stop did not commit pending data");

  read_shift_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
    read_bit_edge |=> s.sda_oe && s.sda_out == $past(s.shift[6]))
    else $error("read bit not shifted out");

  read_release_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
    s.st == i2c_port_pkg::st_ignore |-> !s.sda_oe)
    else $error("data line held after the read byte");

  power_default_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_16
    input_power_lost |=> s.cmd[`IDX_USB_LIMIT][`LIMIT_MSB:`LIMIT_LSB] == $past(lim_val) &&
      s.cmd[`IDX_ADAPTER_LIMIT][`LIMIT_MSB:`LIMIT_LSB] == $past(lim_val))
    else $error("limit fields not defaulted on power loss");

  write_ack_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_24
    s.st == i2c_port_pkg::st_wr_ack |-> s.sda_oe && !s.sda_out)
    else $error("data acknowledge not driven low");

  read_sample_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_17
    addr_byte_end ##0 (s.shift == {`SLAVE_ADDR, `RW_READ}) |=> s.status_sample)
    else $error("status not sampled at read acknowledge");

  foreign_addr_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
    addr_byte_end ##0 (s.shift[7:1] != `SLAVE_ADDR) |=>
      s.st == i2c_port_pkg::st_ignore && !s.sda_oe)
    else $error("foreign address acknowledged");

  write_addr_ack_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
    addr_byte_end ##0 (s.shift == {`SLAVE_ADDR, `RW_WRITE}) |=> s.sda_oe && !s.rw)
    else $error("write address not acknowledged");

  ack_release_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
    ack_clock_end ##0 (s.st == i2c_port_pkg::st_wr_ack) |=>
      s.ptr_phase != $past(s.ptr_phase) && !s.sda_oe)
    else $error("byte position did not alternate");

  first_bit_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
    ack_clock_end ##0 (s.rw == `RW_READ && s.st == i2c_port_pkg::st_addr_ack) |=>
      s.st == i2c_port_pkg::st_rd_byte && s.sda_out == $past(rd_val[7]))
    else $error("read byte did not start from the selected register");
endmodule : i2c_subaddressed_register_port

/* i2c_master_model.sv */
module i2c_master_model (
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Offset keeps line changes off the system clock edges
  task automatic start_cond();
    // Waits out the port's acknowledge release through the input filter
    #63 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #60 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask : stop_cond
  // Data moves well after the clock falls, so filter lag never fakes a START
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #60 sda_drv = tx[i];
      #20 scl = 1'b1;
      #60 rx[i] = sda;
      #20 scl = 1'b0;
    end
    #60 sda_drv = ack_in;
    #20 scl = 1'b1;
    #60 ack = !sda;
    #20 scl = 1'b0;
  endtask : xfer
endmodule : i2c_master_model

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sda_drv, sda_out, sda_oe, irq_b, a;
  logic pwr_lost = 1'b0;
  logic res_mode = 1'b0;
  logic [2:0][7:0] live = '0;
  logic [2:0][7:0] old;
  logic [5:0] ev = '0;
  logic [3:0][7:0] cmd;
  logic [7:0] d, d2, r;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  wire logic sda = sda_drv & !(sda_oe & !sda_out);
  always #5 clk = ~clk;
  i2c_master_model m (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  i2c_subaddressed_register_port i_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .live_status(live),
    .status_events(ev), .input_power_lost(pwr_lost),
    .resistor_programmed_limit_mode(res_mode), .command_regs(cmd), .irq_b(irq_b));
  function automatic logic [4:0] lim(input logic mode);
    return mode ? 5'h1F : 5'h00;
  endfunction : lim
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic put(input logic [7:0] b, input logic ea);
    m.xfer(b, 1'b1, r, a);
    chk("ack", {7'h00, a}, {7'h00, ea});
  endtask : put
  task automatic get(input logic [7:0] e);
    m.xfer(8'hFF, 1'b0, r, a);
    chk("rdata", r, e);
    m.xfer(8'hFF, 1'b1, r, a);
    chk("extra", r, 8'hFF);
    chk("rdack", {7'h00, a}, 8'h00);
  endtask : get
  task automatic fin();
    m.stop_cond();
    repeat (8) @(posedge clk);
  endtask : fin
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    m.start_cond();
    put(8'h12, 1'b1);
    put(p, 1'b1);
    put(v, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    m.start_cond();
    put(8'h12, 1'b1);
    put(p, 1'b1);
    m.start_cond();
    put(8'h13, 1'b1);
    get(e);
    fin();
  endtask : rd
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h3e30));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq", {7'h00, irq_b}, 8'h01);
    d = 8'($urandom());
    wr(8'h02, d);
    m.start_cond();
    put(8'hA0, 1'b0);
    rd(8'h02, d);
    chk("cmd2", cmd[2], d);
    d = 8'($urandom());
    d2 = 8'($urandom());
    wr(8'h00, d);
    put(8'h01, 1'b1);
    put(d2, 1'b1);
    chk("held", cmd[0], 8'h00);
    put(8'h03, 1'b1);
    fin();
    chk("cmd0", cmd[0], d);
    chk("cmd1", cmd[1], d2);
    for (int i = 0; i < 3; i++) begin
      old = {8'($urandom()), 8'($urandom()), 8'($urandom())};
      live <= old;
      rd(8'(3 + i), old[i]);
    end
    live[2] <= 8'($urandom());
    m.start_cond();
    put(8'h13, 1'b1);
    get(live[2]);
    fin();
    wr(8'h06, 8'hFC);
    fin();
    ev <= 6'h3F;
    @(posedge clk) ev <= 6'h00;
    repeat (8) @(posedge clk);
    chk("irq", {7'h00, irq_b}, 8'h00);
    old = live;
    live <= {8'($urandom()), 8'($urandom()), 8'($urandom())};
    rd(8'h03, old[0]);
    wr(8'h06, 8'hFC);
    repeat (8) @(posedge clk);
    chk("irq", {7'h00, irq_b}, 8'h01);
    fin();
    rd(8'h03, live[0]);
    for (int k = 0; k < 2; k++) begin
      res_mode <= k[0];
      pwr_lost <= 1'b1;
      @(posedge clk) pwr_lost <= 1'b0;
      repeat (8) @(posedge clk);
      chk("usb", {3'h0, cmd[0][4:0]}, {3'h0, lim(k[0])});
      chk("wall", {3'h0, cmd[1][4:0]}, {3'h0, lim(k[0])});
    end
    complete_run();
  end
endmodule : tb
